// file: rtl/cev_core.sv
`timescale 1ns/1ns
`default_nettype none
module cev_core #(
   parameter int unsigned TBL_W = 16
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic exc_req_i,
   input wire logic [2:0] exc_src_i,
   input wire logic [7:0] exc_vec_i,
   input wire logic [3:0] trap_op_i,
   // interrupt level pins, asynchronous
   input wire logic [2:0] irq_level_i,
   input wire logic [15:0] sr_i,
   input wire logic vbr_we_i,
   input wire logic [31:0] vbr_d_i,
   output logic bus_req_o,
   output logic [31:0] bus_addr_o,
   output logic [2:0] bus_space_o,
   input wire logic bus_ack_i,
   input wire logic bus_autovec_i,
   input wire logic bus_err_i,
   input wire logic [31:0] bus_data_i,
   output logic [31:0] vector_base_reg_o,
   output logic [15:0] sr_saved_o,
   output logic [15:0] sr_new_o,
   output logic [7:0] vec_num_o,
   output logic [31:0] pc_o,
   output logic [31:0] ssp_o,
   output logic vec_done_o,
   output logic busy_o,
   input wire logic low_power_stop_instr_i,
   input wire logic [2:0] stop_mask_i,
   output logic stopped_o,
   input wire logic decrement_branch_cond_instr_exec_i,
   input wire logic [15:0] decrement_branch_cond_instr_disp_i,
   input wire logic [15:0] decrement_branch_cond_instr_count_i,
   input wire logic body_one_word_i,
   input wire logic body_no_flow_i,
   input wire logic loop_pass_i,
   input wire logic loop_cond_i,
   output logic loop_mode_o,
   output logic fetch_inhibit_o,
   output logic [15:0] loop_cnt_o,
   input wire logic tbl_start_i,
   input wire logic tbl_signed_i,
   input wire logic tbl_round_i,
   input wire logic [TBL_W-1:0] tbl_y0_i,
   input wire logic [TBL_W-1:0] tbl_y1_i,
   input wire logic [7:0] tbl_frac_i,
   output logic [TBL_W+7:0] tbl_result_o,
   output logic tbl_done_o
);
   typedef enum logic [5:0] {
      CEV_RST_SP = 6'b000001,
      CEV_RST_PC = 6'b000010,
      CEV_IDLE = 6'b000100,
      CEV_IACK = 6'b001000,
      CEV_FETCH = 6'b010000,
      CEV_STOP = 6'b100000
   } cev_state_t;

   cev_state_t state_q;
   logic [2:0] irq_s1_q;
   logic [2:0] irq_s2_q;
   logic [2:0] irq_s3_q;
   logic [2:0] irq_lvl_q;
   logic [2:0] stop_mask_q;
   logic [2:0] ack_level_q;
   logic irq_pending;
   logic stop_wake;
   logic take_irq;

   // vector address from base and number
   function automatic logic [31:0] cev_vec_addr(input logic [31:0] base, input logic [7:0] num);
      cev_vec_addr = base + {22'h0, num, 2'b00};
   endfunction

   // internally generated vector number per source
   function automatic logic [7:0] cev_int_vec(input logic [2:0] src, input logic [7:0] vec,
                                              input logic [3:0] op);
      case (src)
         cev_pkg::SRC_TRAP: cev_int_vec = cev_pkg::VEC_TRAP_BASE + {4'h0, op};
         cev_pkg::SRC_FORMAT: cev_int_vec = cev_pkg::VEC_FORMAT_ERR;
         cev_pkg::SRC_UNINIT: cev_int_vec = cev_pkg::VEC_UNINIT_IRQ;
         default: cev_int_vec = vec;
      endcase
   endfunction

   // interrupt pins: three stages, level accepted once stages two and three agree
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         irq_s1_q <= 3'h0;
         irq_s2_q <= 3'h0;
         irq_s3_q <= 3'h0;
         irq_lvl_q <= 3'h0;
      end
      else
      begin
         irq_s1_q <= irq_level_i;
         irq_s2_q <= irq_s1_q;
         irq_s3_q <= irq_s2_q;
         if (irq_s2_q == irq_s3_q)
            irq_lvl_q <= irq_s3_q;
      end
   end

   // level 7 cannot be masked; others must exceed the status mask
   assign irq_pending = (irq_lvl_q != 3'h0) &&
      ((irq_lvl_q == cev_pkg::IRQ_NMI_LEVEL) ||
       (irq_lvl_q > sr_i[cev_pkg::SR_MASK_LO +: 3]));
   // stop wake compares against the mask loaded by the stop instruction
   assign stop_wake = (irq_lvl_q != 3'h0) && (irq_lvl_q >= stop_mask_q);
   // stopped core wakes on its own mask only, idle core on the status mask
   assign take_irq = (state_q == CEV_STOP) ? stop_wake : irq_pending;

   // vector base register, cleared by reset so first vectors sit low
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
         vector_base_reg_o <= 32'h0000_0000;
      else if (vbr_we_i)
         vector_base_reg_o <= vbr_d_i;
   end

   // exception sequencer and vector fetch bus
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         state_q <= CEV_RST_SP;
         bus_req_o <= 1'b0;
         bus_addr_o <= 32'h0000_0000;
         bus_space_o <= cev_pkg::SPACE_SUP_PROG;
         sr_saved_o <= cev_pkg::SR_RESET;
         sr_new_o <= cev_pkg::SR_RESET;
         vec_num_o <= cev_pkg::VEC_RESET_SP;
         pc_o <= 32'h0000_0000;
         ssp_o <= 32'h0000_0000;
         vec_done_o <= 1'b0;
         busy_o <= 1'b1;
         stopped_o <= 1'b0;
         stop_mask_q <= 3'h0;
         ack_level_q <= 3'h0;
      end
      else
      begin
         vec_done_o <= 1'b0;
         case (state_q)
            CEV_RST_SP:
            begin
               // fixed address, program space
               bus_req_o <= 1'b1;
               bus_addr_o <= cev_pkg::RESET_SP_ADDR;
               bus_space_o <= cev_pkg::SPACE_SUP_PROG;
               if (bus_req_o && bus_ack_i)
               begin
                  ssp_o <= bus_data_i;
                  bus_req_o <= 1'b0;
                  vec_num_o <= cev_pkg::VEC_RESET_PC;
                  state_q <= CEV_RST_PC;
               end
            end
            CEV_RST_PC:
            begin
               bus_req_o <= 1'b1;
               bus_addr_o <= cev_pkg::RESET_PC_ADDR;
               bus_space_o <= cev_pkg::SPACE_SUP_PROG;
               if (bus_req_o && bus_ack_i)
               begin
                  pc_o <= bus_data_i;
                  bus_req_o <= 1'b0;
                  vec_done_o <= 1'b1;
                  busy_o <= 1'b0;
                  state_q <= CEV_IDLE;
               end
            end
            CEV_IDLE, CEV_STOP:
            begin
               if (take_irq || (exc_req_i && state_q == CEV_IDLE))
               begin
                  // entry: snapshot status, go supervisor, stop tracing
                  stopped_o <= 1'b0;
                  sr_saved_o <= sr_i;
                  sr_new_o <= sr_i;
                  sr_new_o[cev_pkg::SR_S] <= 1'b1;
                  sr_new_o[cev_pkg::SR_T1] <= 1'b0;
                  sr_new_o[cev_pkg::SR_T0] <= 1'b0;
                  busy_o <= 1'b1;
                  bus_req_o <= 1'b1;
                  if (take_irq)
                  begin
                     // interrupts take priority and raise the mask
                     sr_new_o[cev_pkg::SR_MASK_LO +: 3] <= irq_lvl_q;
                     ack_level_q <= irq_lvl_q;
                     bus_addr_o <= {cev_pkg::IACK_ADDR_HI, irq_lvl_q, 1'b1};
                     bus_space_o <= cev_pkg::SPACE_CPU;
                     state_q <= CEV_IACK;
                  end
                  else
                  begin
                     vec_num_o <= cev_int_vec(exc_src_i, exc_vec_i, trap_op_i);
                     bus_addr_o <= cev_vec_addr(vector_base_reg_o,
                        cev_int_vec(exc_src_i, exc_vec_i, trap_op_i));
                     bus_space_o <= cev_pkg::SPACE_SUP_DATA;
                     state_q <= CEV_FETCH;
                  end
               end
               else if (low_power_stop_instr_i && state_q == CEV_IDLE)
               begin
                  stop_mask_q <= stop_mask_i;
                  stopped_o <= 1'b1;
                  state_q <= CEV_STOP;
               end
            end
            CEV_IACK:
            begin
               if (bus_ack_i)
               begin
                  // any vector the device returns is used unchecked
                  bus_space_o <= cev_pkg::SPACE_SUP_DATA;
                  if (bus_err_i)
                  begin
                     vec_num_o <= cev_pkg::VEC_SPURIOUS;
                     bus_addr_o <= cev_vec_addr(vector_base_reg_o, cev_pkg::VEC_SPURIOUS);
                  end
                  else if (bus_autovec_i)
                  begin
                     vec_num_o <= cev_pkg::VEC_AUTO_BASE + {5'h00, ack_level_q};
                     bus_addr_o <= cev_vec_addr(vector_base_reg_o,
                        cev_pkg::VEC_AUTO_BASE + {5'h00, ack_level_q});
                  end
                  else
                  begin
                     vec_num_o <= bus_data_i[7:0];
                     bus_addr_o <= cev_vec_addr(vector_base_reg_o, bus_data_i[7:0]);
                  end
                  state_q <= CEV_FETCH;
               end
            end
            CEV_FETCH:
            begin
               if (bus_ack_i)
               begin
                  pc_o <= bus_data_i;
                  bus_req_o <= 1'b0;
                  vec_done_o <= 1'b1;
                  busy_o <= 1'b0;
                  state_q <= CEV_IDLE;
               end
            end
            default:
               state_q <= CEV_IDLE;
         endcase
      end
   end

   // loop mode: entry on -4 displacement, pass-by-pass count, exit on exceptions
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         loop_mode_o <= 1'b0;
         fetch_inhibit_o <= 1'b0;
         loop_cnt_o <= 16'h0000;
      end
      else if (loop_mode_o && (state_q != CEV_IDLE || irq_pending || exc_req_i))
      begin
         loop_mode_o <= 1'b0;
         fetch_inhibit_o <= 1'b0;
      end
      else if (loop_mode_o)
      begin
         if (loop_pass_i)
         begin
            // condition true or count running out ends the loop
            loop_cnt_o <= loop_cnt_o - 16'h0001;
            if (loop_cond_i || (loop_cnt_o - 16'h0001) == cev_pkg::LOOP_CNT_END)
            begin
               loop_mode_o <= 1'b0;
               fetch_inhibit_o <= 1'b0;
            end
         end
      end
      else if (decrement_branch_cond_instr_exec_i && decrement_branch_cond_instr_disp_i == cev_pkg::LOOP_DISP &&
               body_one_word_i && body_no_flow_i && !exc_req_i && !irq_pending)
      begin
         loop_mode_o <= 1'b1;
         fetch_inhibit_o <= 1'b1;
         loop_cnt_o <= decrement_branch_cond_instr_count_i;
      end
   end

   // interpolation datapath
   cev_interp #(
      .W(TBL_W)
   ) u_interp (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .start_i(tbl_start_i),
      .signed_i(tbl_signed_i),
      .round_i(tbl_round_i),
      .y0_i(tbl_y0_i),
      .y1_i(tbl_y1_i),
      .frac_i(tbl_frac_i),
      .result_o(tbl_result_o),
      .done_o(tbl_done_o)
   );
endmodule
`default_nettype wire

// file: inc/cev_pkg.sv
`default_nettype none
package cev_pkg;
   // vector table geometry
   localparam int unsigned TABLE_ENTRIES = 256;
   localparam int unsigned TABLE_BYTES = 1024;
   localparam int unsigned VEC_W = 8;
   localparam int unsigned ADDR_W = 32;
   localparam int unsigned VEC_SHIFT = 2;
   // fixed reset fetch addresses (vector 0 and 1)
   localparam logic [31:0] RESET_SP_ADDR = 32'h0000_0000;
   localparam logic [31:0] RESET_PC_ADDR = 32'h0000_0004;
   // processor-defined vector numbers
   localparam logic [7:0] VEC_RESET_SP = 8'h00;
   localparam logic [7:0] VEC_RESET_PC = 8'h01;
   localparam logic [7:0] VEC_FORMAT_ERR = 8'h0e;
   localparam logic [7:0] VEC_UNINIT_IRQ = 8'h0f;
   localparam logic [7:0] VEC_SPURIOUS = 8'h18;
   localparam logic [7:0] VEC_AUTO_BASE = 8'h18;
   localparam logic [7:0] VEC_TRAP_BASE = 8'h20;
   localparam logic [7:0] VEC_PROC_LAST = 8'h3f;
   localparam logic [7:0] VEC_USER_FIRST = 8'h40;
   // exception source selects
   localparam logic [2:0] SRC_INTERNAL = 3'h0;
   localparam logic [2:0] SRC_TRAP = 3'h1;
   localparam logic [2:0] SRC_FORMAT = 3'h2;
   localparam logic [2:0] SRC_UNINIT = 3'h3;
   // bus space codes
   localparam logic [2:0] SPACE_SUP_DATA = 3'h5;
   localparam logic [2:0] SPACE_SUP_PROG = 3'h6;
   localparam logic [2:0] SPACE_CPU = 3'h7;
   // interrupt acknowledge address in cpu space
   localparam logic [27:0] IACK_ADDR_HI = 28'hfff_ffff;
   // status register fields
   localparam int unsigned SR_T1 = 15;
   localparam int unsigned SR_T0 = 14;
   localparam int unsigned SR_S = 13;
   localparam int unsigned SR_MASK_LO = 8;
   localparam logic [15:0] SR_RESET = 16'h2700;
   localparam logic [2:0] IRQ_NMI_LEVEL = 3'h7;
   // loop mode entry displacement (-4)
   localparam logic [15:0] LOOP_DISP = 16'hfffc;
   localparam logic [15:0] LOOP_CNT_END = 16'hffff;
endpackage
`default_nettype wire

// file: rtl/cev_interp.sv
`timescale 1ns/1ns
`default_nettype none
// table interpolation between two sample points, one cycle latency
module cev_interp #(
   parameter int unsigned W = 16
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic start_i,
   input wire logic signed_i,
   input wire logic round_i,
   input wire logic [W-1:0] y0_i,
   input wire logic [W-1:0] y1_i,
   input wire logic [7:0] frac_i,
   output logic [W+7:0] result_o,
   output logic done_o
);
   logic signed [W+1:0] y0_x;
   logic signed [W+1:0] y1_x;
   logic signed [W+1:0] diff;
   logic signed [W+10:0] prod;
   logic signed [W+10:0] scaled;
   logic [W+7:0] result_d;

   // difference times fraction, extended by sign mode
   always_comb
   begin
      y0_x = signed_i ? {{2{y0_i[W-1]}}, y0_i} : {2'b00, y0_i};
      y1_x = signed_i ? {{2{y1_i[W-1]}}, y1_i} : {2'b00, y1_i};
      diff = y1_x - y0_x;
      prod = diff * $signed({1'b0, frac_i});
      // rounding form scales back down with round-to-nearest
      scaled = (prod + (W+11)'(128)) >>> 8;
      if (round_i)
         result_d = (W+8)'(y0_x + $signed(scaled[W+1:0]));
      else
         result_d = (W+8)'(({{9{y0_x[W+1]}}, y0_x} <<< 8) + prod);
   end

   // registered result so the core's outputs come from flops
   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         result_o <= '0;
         done_o <= 1'b0;
      end
      else
      begin
         done_o <= start_i;
         if (start_i)
            result_o <= result_d;
      end
   end
endmodule
`default_nettype wire

// file: testbench/cev_core_props.sv
`timescale 1ns/1ns
`default_nettype none
// pin-level checks of the vector sequencer, loop mode and stop wake
module cev_core_props (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic exc_req_i,
   input wire logic bus_req_o,
   input wire logic [31:0] bus_addr_o,
   input wire logic [2:0] bus_space_o,
   input wire logic [31:0] vector_base_reg_o,
   input wire logic [15:0] sr_new_o,
   input wire logic [7:0] vec_num_o,
   input wire logic vec_done_o,
   input wire logic busy_o,
   input wire logic stopped_o,
   input wire logic decrement_branch_cond_instr_exec_i,
   input wire logic [15:0] decrement_branch_cond_instr_disp_i,
   input wire logic [15:0] decrement_branch_cond_instr_count_i,
   input wire logic body_one_word_i,
   input wire logic body_no_flow_i,
   input wire logic loop_pass_i,
   input wire logic loop_cond_i,
   input wire logic loop_mode_o,
   input wire logic fetch_inhibit_o,
   input wire logic [15:0] loop_cnt_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);
   // program space only ever carries the two fixed reset words
   prog_space_a: assert property (bus_req_o && bus_space_o == cev_pkg::SPACE_SUP_PROG
      |-> bus_addr_o == 32'h0 || bus_addr_o == 32'h4) else $error("program space misuse");
   fetch_addr_a: assert property (bus_req_o && bus_space_o == cev_pkg::SPACE_SUP_DATA
      |-> bus_addr_o == vector_base_reg_o + {22'h0, vec_num_o, 2'b00}) else $error("bad address");
   iack_addr_a: assert property (bus_req_o && bus_space_o == cev_pkg::SPACE_CPU
      |-> bus_addr_o[31:4] == cev_pkg::IACK_ADDR_HI && bus_addr_o[0]) else $error("bad iack");
   sr_entry_a: assert property (vec_done_o |-> sr_new_o[15:13] == 3'b001)
      else $error("status not supervisor");
   // irq pins are kept quiet by the bench whenever a loop is entered
   loop_entry_a: assert property (decrement_branch_cond_instr_exec_i && decrement_branch_cond_instr_disp_i == cev_pkg::LOOP_DISP
      && body_one_word_i && body_no_flow_i && !busy_o && !exc_req_i && !loop_mode_o
      |=> loop_mode_o && loop_cnt_o == $past(decrement_branch_cond_instr_count_i)) else $error("loop not entered");
   loop_count_a: assert property (loop_mode_o && loop_pass_i && !loop_cond_i
      && loop_cnt_o != 16'h0 && !exc_req_i && !busy_o
      |=> loop_mode_o && loop_cnt_o == $past(loop_cnt_o) - 16'h1) else $error("bad count");
   loop_exit_a: assert property (loop_mode_o && exc_req_i |=> !loop_mode_o)
      else $error("loop kept on exception");
   inhibit_a: assert property (fetch_inhibit_o == loop_mode_o)
      else $error("fetch inhibit mismatch");
   wake_iack_a: assert property ($fell(stopped_o)
      |-> ##[0:1] bus_req_o && bus_space_o == cev_pkg::SPACE_CPU) else $error("wake not iack");
   cover property (loop_mode_o && loop_pass_i);
   cover property ($fell(stopped_o));
   cover property (bus_req_o && bus_space_o == cev_pkg::SPACE_CPU);
endmodule
bind cev_core cev_core_props u_props (.clk_i, .nrst_i, .exc_req_i, .bus_req_o, .bus_addr_o,
   .bus_space_o, .vector_base_reg_o, .sr_new_o, .vec_num_o, .vec_done_o, .busy_o, .stopped_o,
   .decrement_branch_cond_instr_exec_i, .decrement_branch_cond_instr_disp_i, .decrement_branch_cond_instr_count_i, .body_one_word_i, .body_no_flow_i, .loop_pass_i,
   .loop_cond_i, .loop_mode_o, .fetch_inhibit_o, .loop_cnt_o);
`default_nettype wire

// file: testbench/cev_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
// memory and interrupting peripheral on the vector bus
module cev_bus_model (
   input wire logic clk_i,
   input wire logic req_i,
   input wire logic [31:0] addr_i,
   input wire logic [2:0] space_i,
   input wire logic [3:0] wait_i,
   input wire logic [1:0] mode_i,
   input wire logic [7:0] vec_i,
   output logic ack_o,
   output logic autovec_o,
   output logic err_o,
   output logic [31:0] data_o
);
   logic [3:0] cnt_q = 4'h0;
   logic ack_q = 1'b0;
   logic [31:0] last_q = 32'h0;
   logic iack;
   assign iack = space_i == cev_pkg::SPACE_CPU;
   assign ack_o = ack_q;
   assign autovec_o = ack_q && iack && mode_i == 2'h1;
   assign err_o = ack_q && iack && mode_i == 2'h2;
   // released data shows the inverse, so a stale sample never looks right
   assign data_o = ack_q ? last_q : ~last_q;
   // one ack per request after wait_i idle cycles
   always @(posedge clk_i)
   begin
      if (ack_q || !req_i)
      begin
         ack_q <= 1'b0;
         cnt_q <= 4'h0;
      end
      else if (cnt_q == wait_i)
      begin
         ack_q <= 1'b1;
         last_q <= iack ? {24'h0, vec_i} : {~addr_i[15:0], addr_i[15:0]};
      end
      else
         cnt_q <= cnt_q + 4'h1;
   end
endmodule
`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
   $display("BAD %s expected %h seen %h", nm, e, g); end end
module tb;
   logic clk_i = 1'b0, nrst_i = 1'b0, exc_req_i = 1'b0, vbr_we_i = 1'b0;
   logic low_power_stop_instr_i = 1'b0, decrement_branch_cond_instr_exec_i = 1'b0, body_one_word_i = 1'b0;
   logic body_no_flow_i = 1'b0, loop_pass_i = 1'b0, loop_cond_i = 1'b0, tbl_start_i = 1'b0;
   logic tbl_signed_i = 1'b0, tbl_round_i = 1'b0;
   logic [2:0] exc_src_i = 3'h0, irq_level_i = 3'h0, stop_mask_i = 3'h0;
   logic [7:0] exc_vec_i = 8'h0, tbl_frac_i = 8'h0, ivec_q = 8'h0;
   logic [3:0] trap_op_i = 4'h0, wait_q = 4'h0;
   logic [1:0] mode_q = 2'h0;
   logic [15:0] sr_i = 16'hc000, decrement_branch_cond_instr_disp_i = 16'h0, decrement_branch_cond_instr_count_i = 16'h0;
   logic [15:0] tbl_y0_i = 16'h0, tbl_y1_i = 16'h0;
   logic [31:0] vbr_d_i = 32'h0, bus_data_i, bus_addr_o, vector_base_reg_o, pc_o, ssp_o;
   logic bus_ack_i, bus_autovec_i, bus_err_i, bus_req_o, vec_done_o, busy_o, stopped_o;
   logic loop_mode_o, fetch_inhibit_o, tbl_done_o;
   logic [2:0] bus_space_o;
   logic [15:0] sr_saved_o, sr_new_o, loop_cnt_o;
   logic [7:0] vec_num_o;
   logic [23:0] tbl_result_o;
   int fail_count = 0;
   int n_compared = 0;
   cev_core dut (.clk_i, .nrst_i, .exc_req_i, .exc_src_i, .exc_vec_i, .trap_op_i, .irq_level_i,
      .sr_i, .vbr_we_i, .vbr_d_i, .bus_req_o, .bus_addr_o, .bus_space_o, .bus_ack_i,
      .bus_autovec_i, .bus_err_i, .bus_data_i, .vector_base_reg_o, .sr_saved_o, .sr_new_o,
      .vec_num_o, .pc_o, .ssp_o, .vec_done_o, .busy_o, .low_power_stop_instr_i, .stop_mask_i,
      .stopped_o, .decrement_branch_cond_instr_exec_i, .decrement_branch_cond_instr_disp_i, .decrement_branch_cond_instr_count_i, .body_one_word_i, .body_no_flow_i,
      .loop_pass_i, .loop_cond_i, .loop_mode_o, .fetch_inhibit_o, .loop_cnt_o, .tbl_start_i,
      .tbl_signed_i, .tbl_round_i, .tbl_y0_i, .tbl_y1_i, .tbl_frac_i, .tbl_result_o, .tbl_done_o);
   cev_bus_model mem (.clk_i, .req_i(bus_req_o), .addr_i(bus_addr_o), .space_i(bus_space_o),
      .wait_i(wait_q), .mode_i(mode_q), .vec_i(ivec_q), .ack_o(bus_ack_i),
      .autovec_o(bus_autovec_i), .err_o(bus_err_i), .data_o(bus_data_i));
   always #25 clk_i = ~clk_i;
   // word the memory model returns for an address
   function automatic logic [31:0] mw(input logic [31:0] a);
      return {~a[15:0], a[15:0]};
   endfunction
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic idle();
      for (int i = 0; i < 60 && busy_o !== 1'b0; i++)
         @(negedge clk_i);
   endtask
   // wait for the new pc, then judge vector number, address and status
   task automatic fin(input logic [7:0] ev);
      logic [31:0] fa;
      logic [31:0] a;
      fa = 32'h0;
      a = vbr_d_i + {22'h0, ev, 2'b00};
      for (int i = 0; i < 80 && vec_done_o !== 1'b1; i++)
      begin
         @(negedge clk_i);
         if (bus_req_o && bus_space_o === cev_pkg::SPACE_SUP_DATA)
            fa = bus_addr_o;
      end
      `CHK("done", 1'b1, vec_done_o)
      `CHK("vec", ev, vec_num_o)
      `CHK("addr", a, fa)
      `CHK("pc", mw(a), pc_o)
      `CHK("sr_saved", sr_i, sr_saved_o)
      `CHK("sr_new", 3'b001, sr_new_o[15:13])
      idle();
      @(negedge clk_i);
   endtask
   task automatic t_vbr(input logic [31:0] v);
      vbr_d_i = v;
      vbr_we_i = 1'b1;
      @(negedge clk_i);
      vbr_we_i = 1'b0;
      `CHK("vbr", v, vector_base_reg_o)
   endtask
   task automatic t_exc(input logic [2:0] s, input logic [7:0] v, input logic [3:0] op,
      input logic [7:0] ev);
      exc_src_i = s;
      exc_vec_i = v;
      trap_op_i = op;
      exc_req_i = 1'b1;
      @(negedge clk_i);
      exc_req_i = 1'b0;
      fin(ev);
   endtask
   // level dropped once the acknowledge is under way, so it is taken once
   task automatic t_irq(input logic [2:0] l, input logic [1:0] m, input logic [7:0] iv,
      input logic [7:0] ev);
      mode_q = m;
      ivec_q = iv;
      irq_level_i = l;
      repeat (6) @(negedge clk_i);
      irq_level_i = 3'h0;
      fin(ev);
      `CHK("irq_mask", l, sr_new_o[10:8])
      repeat (4) @(negedge clk_i);
   endtask
   task automatic t_stop();
      stop_mask_i = 3'h5;
      low_power_stop_instr_i = 1'b1;
      @(negedge clk_i);
      low_power_stop_instr_i = 1'b0;
      `CHK("stopped", 1'b1, stopped_o)
      irq_level_i = 3'h4;
      repeat (8) @(negedge clk_i);
      `CHK("below_mask", 1'b1, stopped_o)
      irq_level_i = 3'h0;
      repeat (4) @(negedge clk_i);
      t_irq(3'h5, 2'h1, 8'h0, 8'h1d);
      `CHK("woken", 1'b0, stopped_o)
   endtask
   task automatic t_loop(input logic [15:0] d, input logic ow, input logic nf,
      input logic [15:0] n, input logic e);
      decrement_branch_cond_instr_disp_i = d;
      body_one_word_i = ow;
      body_no_flow_i = nf;
      decrement_branch_cond_instr_count_i = n;
      decrement_branch_cond_instr_exec_i = 1'b1;
      @(negedge clk_i);
      decrement_branch_cond_instr_exec_i = 1'b0;
      `CHK("loop", e, loop_mode_o)
      `CHK("inhibit", e, fetch_inhibit_o)
      @(negedge clk_i);
   endtask
   task automatic pass(input logic c, input logic [15:0] ec, input logic el);
      loop_cond_i = c;
      loop_pass_i = 1'b1;
      @(negedge clk_i);
      loop_pass_i = 1'b0;
      `CHK("count", ec, loop_cnt_o)
      `CHK("looping", el, loop_mode_o)
      @(negedge clk_i);
   endtask
   task automatic t_tbl(input logic s, input logic r, input logic [15:0] a,
      input logic [15:0] b, input logic [7:0] f, input logic [23:0] e);
      tbl_signed_i = s;
      tbl_round_i = r;
      tbl_y0_i = a;
      tbl_y1_i = b;
      tbl_frac_i = f;
      tbl_start_i = 1'b1;
      @(negedge clk_i);
      tbl_start_i = 1'b0;
      `CHK("tbl_done", 1'b1, tbl_done_o)
      `CHK("tbl", e, tbl_result_o)
      @(negedge clk_i);
   endtask
   // bounded by about 40000 cycles, far beyond the whole sequence
   initial
   begin
      #2000000;
      fail_count++;
      $display("BAD watchdog expected finish seen hang");
      final_report();
   end
   initial
   begin
      repeat (4) @(negedge clk_i);
      nrst_i = 1'b1;
      @(negedge clk_i);
      `CHK("req", 1'b1, bus_req_o)
      `CHK("sp_addr", cev_pkg::RESET_SP_ADDR, bus_addr_o)
      `CHK("space", cev_pkg::SPACE_SUP_PROG, bus_space_o)
      idle();
      `CHK("ssp", mw(32'h0), ssp_o)
      `CHK("rst_pc", mw(32'h4), pc_o)
      t_vbr(32'h0001_0000);
      t_exc(cev_pkg::SRC_FORMAT, 8'h0, 4'h0, 8'h0e);
      t_exc(cev_pkg::SRC_UNINIT, 8'h0, 4'h0, 8'h0f);
      t_exc(cev_pkg::SRC_TRAP, 8'h0, 4'h0, 8'h20);
      t_exc(cev_pkg::SRC_TRAP, 8'h0, 4'hf, 8'h2f);
      t_vbr(32'h00ab_cd00);
      t_exc(cev_pkg::SRC_INTERNAL, 8'h0d, 4'h0, 8'h0d);
      t_exc(cev_pkg::SRC_INTERNAL, 8'h30, 4'h0, 8'h30);
      t_exc(cev_pkg::SRC_INTERNAL, 8'hff, 4'h0, 8'hff);
      wait_q = 4'h4;
      t_irq(3'h2, 2'h0, 8'h40, 8'h40);
      t_irq(3'h3, 2'h0, 8'h05, 8'h05);
      for (int k = 1; k < 8; k++)
         t_irq(3'(k), 2'h1, 8'h0, 8'(8'h18 + k));
      t_irq(3'h6, 2'h2, 8'h0, 8'h18);
      t_stop();
      wait_q = 4'h0;
      t_loop(16'hfffc, 1'b1, 1'b1, 16'h0002, 1'b1);
      pass(1'b0, 16'h0001, 1'b1);
      pass(1'b0, 16'h0000, 1'b1);
      pass(1'b0, 16'hffff, 1'b0);
      t_loop(16'hfffc, 1'b1, 1'b1, 16'h0005, 1'b1);
      pass(1'b1, 16'h0004, 1'b0);
      t_loop(16'hfffe, 1'b1, 1'b1, 16'h0005, 1'b0);
      t_loop(16'hfffc, 1'b0, 1'b1, 16'h0005, 1'b0);
      t_loop(16'hfffc, 1'b1, 1'b0, 16'h0005, 1'b0);
      t_loop(16'hfffc, 1'b1, 1'b1, 16'h0100, 1'b1);
      t_exc(cev_pkg::SRC_TRAP, 8'h0, 4'h7, 8'h27);
      `CHK("loop_left", 1'b0, loop_mode_o)
      t_tbl(1'b0, 1'b0, 16'd100, 16'd200, 8'h80, 24'h009600);
      t_tbl(1'b0, 1'b1, 16'h0000, 16'h0003, 8'h80, 24'h000002);
      t_tbl(1'b1, 1'b0, 16'hff00, 16'h0100, 8'h40, 24'hff8000);
      t_tbl(1'b1, 1'b1, 16'hff00, 16'h0100, 8'h40, 24'hffff80);
      final_report();
   end
endmodule
`default_nettype wire
